// ===== logic/srm_pkg.sv
// shared constants and types of the serial register map block
package srm_pkg;

	// ------------------------------------------------------------
	// header byte layout and access prefixes
	// ------------------------------------------------------------
	localparam int HDR_RNW_BIT   = 7;         // 1 = read, 0 = write
	localparam int HDR_BURST_BIT = 6;         // 1 = burst access
	localparam int ADDR_W        = 6;         // address field width

	// ------------------------------------------------------------
	// address map
	// ------------------------------------------------------------
	localparam logic [5:0] CFG_BASE_ADDR  = 6'h00; // config region start
	localparam logic [5:0] UPPER_BASE     = 6'h30; // strobes and status
	localparam logic [5:0] RESET_STB_ADDR = 6'h30; // reset_strobe
	localparam logic [5:0] AUX_CFG_ADDR   = 6'h01; // aux_output_pin_config
	localparam logic [5:0] MAIN_ST_ADDR   = 6'h35; // main_state_status
	localparam logic [5:0] PKT_ST_ADDR    = 6'h38; // packet_status
	localparam logic [5:0] TX_CNT_ADDR    = 6'h3A; // tx_byte_count
	localparam logic [5:0] PWR_TBL_ADDR   = 6'h3E; // power_level_table
	localparam logic [5:0] TX_BUF_ADDR    = 6'h3F; // transmit buffer
	localparam logic [5:0] PWR_MEM_BASE   = 6'h30; // table rows in memory

	// ------------------------------------------------------------
	// aux_output_pin_config fields and reset value
	// ------------------------------------------------------------
	localparam int         DRIVE_BIT      = 7;      // output_drive_strength
	localparam int         INV_BIT        = 6;      // aux_pin_invert
	localparam logic [7:0] AUX_CFG_RESET  = 8'h2E;  // tri-state select
	localparam logic [5:0] SEL_TRISTATE   = 6'h2E;  // high-impedance code
	localparam logic [7:0] CFG_RESET      = 8'h00;  // other storage bytes

	// ------------------------------------------------------------
	// transfer state machine, one-hot
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,  // chip select released
		ST_HDR    = 4'b0010,  // shifting the header byte
		ST_DATA   = 4'b0100,  // data bytes of a register access
		ST_STROBE = 4'b1000   // strobe issued, rest of frame ignored
	} srm_st_t;

	// whole state of the register map
	typedef struct packed {
		srm_st_t    st;       // transfer phase
		logic       sclk_q;   // serial clock one cycle ago
		logic [2:0] bits;     // bits of the current byte
		logic [7:0] sin;      // receive shifter
		logic [7:0] sout;     // transmit shifter, msb on the pin
		logic       rnw;      // current access is a read
		logic       burst;    // current access is a burst
		logic [5:0] addr;     // current register address
		logic [2:0] pa_idx;   // row inside the power table
		logic [7:0] aux;      // shadow of aux_output_pin_config
		logic       stb_v;    // strobe pulse
		logic [5:0] stb_code; // strobe address
		logic       tx_v;     // transmit buffer write pulse
		logic [7:0] tx_d;     // transmit buffer byte
		logic       pin_o;    // aux pin level after inversion
	} srm_state_t;

	// memory write port bundle
	typedef struct packed {
		logic       en;   // write strobe
		logic [5:0] addr; // word index
		logic [7:0] data; // byte to store
	} srm_wr_t;

endpackage : srm_pkg

// ===== logic/srm_mem.sv
// byte store of the configuration and power table words
`timescale 1ns/1ns
module srm_mem #(
	parameter int DEPTH = 64        // number of byte words
) (
	input  wire logic          mclk,    // system clock
	input  wire logic          rst_n,   // async reset, active low
	input  wire logic          clr,     // soft reset of all words
	input  wire srm_pkg::srm_wr_t wr,   // write port
	input  wire logic          rd_en,   // read strobe
	input  wire logic [5:0]    rd_addr, // read index
	output logic      [7:0]    rd_data  // registered read data
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	// words reset to their defaults so software sees known values
	logic [7:0] mem_r [DEPTH];  // byte array

	// reset value of one word
	function automatic logic [7:0] word_default(input int idx);
		if (idx == int'(srm_pkg::AUX_CFG_ADDR))
			word_default = srm_pkg::AUX_CFG_RESET;
		else
			word_default = srm_pkg::CFG_RESET;
	endfunction : word_default

	// write and clear, clear has priority over a write
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= word_default(i);
		end
		else if (clr)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= word_default(i);
		end
		else if (wr.en)
		begin
			mem_r[wr.addr] <= wr.data;
		end
	end

	// read data comes from a register, held between reads
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rd_data <= 8'h00;
		else if (rd_en)
			rd_data <= mem_r[rd_addr];
	end

endmodule : srm_mem

// ===== logic/srm_regmap.sv
// serial register map with aux output pin configuration
// Behaviour
// RULE1: config registers from 0x00, single and burst
// RULE2: addresses 0x30 up are strobes, status, multi-byte
// RULE3: prefix 0xC0 on upper region reads status
// RULE4: bit 7 sets drive strength, resets 0
// RULE5: bit 6 inverts aux pin, resets 0
// RULE6: bits 5:0 select signal, 0x2E tri-state
// RULE7: header: rw bit7, burst bit6, address 5:0
`timescale 1ns/1ns
module srm_regmap (
	input  wire logic       mclk,            // system clock, 125 MHz
	input  wire logic       rst_n,           // async reset, active low
	input  wire logic       spi_sclk,        // serial clock from host
	input  wire logic       spi_cs_n,        // chip select, active low
	input  wire logic       spi_mosi,        // serial data in
	output logic            spi_miso,        // serial data out
	output logic            spi_miso_oe,     // miso driven while selected
	input  wire logic [7:0] chip_status,     // byte sent during header
	input  wire logic [7:0] main_state_status, // status word
	input  wire logic [7:0] packet_status,   // status word
	input  wire logic [7:0] tx_byte_count,   // status word
	input  wire logic       aux_signal,      // signal picked by select
	output logic            strobe_valid,    // one-cycle strobe pulse
	output logic [5:0]      strobe_code,     // address of the strobe
	output logic            tx_wr_valid,     // one-cycle buffer write
	output logic [7:0]      tx_wr_data,      // byte for the buffer
	output logic [5:0]      aux_pin_signal_select, // select field
	output logic            output_drive_strength, // 1 = high drive
	output logic            aux_pin_o,       // aux pin level
	output logic            aux_pin_oe       // aux pin enable
);

	// ------------------------------------------------------------
	// state and decode helpers
	// ------------------------------------------------------------
	srm_pkg::srm_state_t s_r;      // registered state
	srm_pkg::srm_state_t s_nxt;    // next state
	srm_pkg::srm_wr_t    wr_nxt;   // memory write
	logic                rd_en_nxt;   // memory read strobe
	logic [5:0]          rd_addr_nxt; // memory read index
	logic                clr_nxt;     // soft reset of storage
	logic [7:0]          mem_q;       // memory read data
	logic                rise;        // serial clock rising
	logic                fall;        // serial clock falling
	logic [7:0]          byte_in;     // byte completing this cycle
	logic                byte_done;   // eighth bit sampled

	// memory word behind an address, table rows by index
	function automatic logic [5:0] mem_index(input logic [5:0] a,
		input logic [2:0] row);
		if (a == srm_pkg::PWR_TBL_ADDR)
			mem_index = srm_pkg::PWR_MEM_BASE | {3'h0, row};
		else
			mem_index = a;
	endfunction : mem_index

	// address names a stored byte
	function automatic logic stored(input logic [5:0] a);
		stored = (a < srm_pkg::UPPER_BASE) || (a == srm_pkg::PWR_TBL_ADDR);
	endfunction : stored

	assign rise      = spi_sclk & ~s_r.sclk_q;
	assign fall      = ~spi_sclk & s_r.sclk_q;
	assign byte_in   = {s_r.sin[6:0], spi_mosi};
	assign byte_done = rise && (s_r.bits == 3'h7);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// host is expected to run sclk at most mclk/8 so edges are seen
	always_comb
	begin
		s_nxt        = s_r;
		s_nxt.sclk_q = spi_sclk;
		s_nxt.stb_v  = 1'b0;
		s_nxt.tx_v   = 1'b0;
		wr_nxt       = '0;
		rd_en_nxt    = 1'b0;
		rd_addr_nxt  = 6'h00;
		clr_nxt      = 1'b0;
		// inversion applied after the select has picked its signal
		// RULE5: polarity of aux pin
		s_nxt.pin_o = aux_signal ^ s_r.aux[srm_pkg::INV_BIT];
		if (rise)
		begin
			s_nxt.sin  = byte_in;
			s_nxt.bits = s_r.bits + 3'h1;
		end
		case (s_r.st)
			srm_pkg::ST_IDLE:
			begin
				// frame opens, status byte goes out with the header
				if (!spi_cs_n)
				begin
					s_nxt.st     = srm_pkg::ST_HDR;
					s_nxt.bits   = 3'h0;
					s_nxt.sout   = chip_status;
					s_nxt.pa_idx = 3'h0;
				end
			end
			srm_pkg::ST_HDR:
			begin
				if (byte_done)
				begin
					// RULE7: header byte decode
					s_nxt.rnw   = byte_in[srm_pkg::HDR_RNW_BIT];
					s_nxt.burst = byte_in[srm_pkg::HDR_BURST_BIT];
					s_nxt.addr  = byte_in[5:0];
					// RULE2: strobe decode upper region
					if (byte_in[5:0] >= srm_pkg::UPPER_BASE &&
						byte_in[5:0] < srm_pkg::PWR_TBL_ADDR &&
						byte_in[7:6] != 2'b11)
					begin
						s_nxt.st       = srm_pkg::ST_STROBE;
						s_nxt.stb_v    = 1'b1;
						s_nxt.stb_code = byte_in[5:0];
						clr_nxt = (byte_in[5:0] == srm_pkg::RESET_STB_ADDR);
					end
					else
					begin
						s_nxt.st    = srm_pkg::ST_DATA;
						rd_en_nxt   = byte_in[srm_pkg::HDR_RNW_BIT];
						rd_addr_nxt = mem_index(byte_in[5:0], 3'h0);
					end
				end
			end
			srm_pkg::ST_DATA:
			begin
				// RULE1: read and write of stored bytes
				if (byte_done && !s_r.rnw)
				begin
					wr_nxt.en   = stored(s_r.addr);
					wr_nxt.addr = mem_index(s_r.addr, s_r.pa_idx);
					wr_nxt.data = byte_in;
					if (s_r.addr == srm_pkg::AUX_CFG_ADDR)
						s_nxt.aux = byte_in;
					if (s_r.addr == srm_pkg::TX_BUF_ADDR)
					begin
						s_nxt.tx_v = 1'b1;
						s_nxt.tx_d = byte_in;
					end
				end
				else if (byte_done)
				begin
					rd_en_nxt   = 1'b1;
					rd_addr_nxt = mem_index(s_r.addr, s_r.pa_idx);
				end
				// burst moves on after each byte; table walks rows,
				// buffer and status addresses stay put
				if (byte_done && !s_r.rnw && s_r.burst)
				begin
					if (s_r.addr == srm_pkg::PWR_TBL_ADDR)
						s_nxt.pa_idx = s_r.pa_idx + 3'h1;
					else if (s_r.addr < srm_pkg::UPPER_BASE)
						s_nxt.addr = s_r.addr + 6'h01;
				end
			end
			srm_pkg::ST_STROBE:
			begin
				// further bytes of a strobe frame are ignored
				s_nxt.st = srm_pkg::ST_STROBE;
			end
			default:
			begin
				s_nxt.st = srm_pkg::ST_IDLE;
			end
		endcase
		// falling edge: next bit out, or a fresh read byte
		if (fall && s_r.st != srm_pkg::ST_IDLE)
		begin
			if (s_r.bits == 3'h0 && s_r.st == srm_pkg::ST_DATA && s_r.rnw)
			begin
				// RULE3: status reads with 0xC0 prefix
				if (s_r.addr == srm_pkg::MAIN_ST_ADDR)
					s_nxt.sout = main_state_status;
				else if (s_r.addr == srm_pkg::PKT_ST_ADDR)
					s_nxt.sout = packet_status;
				else if (s_r.addr == srm_pkg::TX_CNT_ADDR)
					s_nxt.sout = tx_byte_count;
				else if (stored(s_r.addr))
					s_nxt.sout = mem_q;
				else
					s_nxt.sout = 8'h00;
				if (s_r.burst && s_r.addr == srm_pkg::PWR_TBL_ADDR)
					s_nxt.pa_idx = s_r.pa_idx + 3'h1;
				else if (s_r.burst && s_r.addr < srm_pkg::UPPER_BASE)
					s_nxt.addr = s_r.addr + 6'h01;
			end
			else
			begin
				s_nxt.sout = {s_r.sout[6:0], 1'b0};
			end
		end
		// soft reset restores the pin configuration too
		if (clr_nxt)
			s_nxt.aux = srm_pkg::AUX_CFG_RESET;
		// release of chip select ends any frame at once
		if (spi_cs_n)
		begin
			s_nxt.st   = srm_pkg::ST_IDLE;
			s_nxt.bits = 3'h0;
		end
	end

	// register the whole state
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_r        <= '0;
			s_r.st     <= srm_pkg::ST_IDLE;
			s_r.aux    <= srm_pkg::AUX_CFG_RESET;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// storage of configuration bytes and table rows
	srm_mem #(
		.DEPTH (64)
	) u_mem (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.clr     (clr_nxt),
		.wr      (wr_nxt),
		.rd_en   (rd_en_nxt),
		.rd_addr (rd_addr_nxt),
		.rd_data (mem_q)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign spi_miso     = s_r.sout[7];
	assign spi_miso_oe  = (s_r.st != srm_pkg::ST_IDLE);
	assign strobe_valid = s_r.stb_v;
	assign strobe_code  = s_r.stb_code;
	assign tx_wr_valid  = s_r.tx_v;
	assign tx_wr_data   = s_r.tx_d;
	// RULE4: drive strength for all pins
	assign output_drive_strength = s_r.aux[srm_pkg::DRIVE_BIT];
	// RULE6: signal select and tri-state
	assign aux_pin_signal_select = s_r.aux[5:0];
	assign aux_pin_oe = (s_r.aux[5:0] != srm_pkg::SEL_TRISTATE);
	assign aux_pin_o  = s_r.pin_o;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	aux_write_a: assert property ( // RULE1
		(s_r.st == srm_pkg::ST_DATA && !s_r.rnw && byte_done &&
		 s_r.addr == srm_pkg::AUX_CFG_ADDR) |=> s_r.aux == $past(byte_in))
		else $error("aux register write lost");
	strobe_decode_a: assert property ( // RULE2
		strobe_valid |-> strobe_code >= srm_pkg::UPPER_BASE &&
		 $past(s_r.st) == srm_pkg::ST_HDR)
		else $error("strobe outside upper region");
	status_read_a: assert property ( // RULE3
		(fall && s_r.st == srm_pkg::ST_DATA && s_r.rnw && s_r.bits == 3'h0
		 && s_r.addr == srm_pkg::PKT_ST_ADDR) |=> s_r.sout == $past(packet_status))
		else $error("status byte not loaded");
	drive_bit_a: assert property ( // RULE4
		$changed(output_drive_strength) |->
		 ($past(wr_nxt.en) &&
		  $past(wr_nxt.addr) == srm_pkg::AUX_CFG_ADDR &&
		  output_drive_strength == $past(wr_nxt.data[7]))
		 || $past(clr_nxt))
		else $error("drive strength changed without write");
	invert_a: assert property ( // RULE5
		##1 aux_pin_o == ($past(aux_signal) ^ $past(s_r.aux[6])))
		else $error("aux pin polarity wrong");
	tristate_a: assert property ( // RULE6
		$past(clr_nxt) ||
		 aux_pin_signal_select == srm_pkg::SEL_TRISTATE |->
		 !aux_pin_oe && aux_pin_signal_select == srm_pkg::SEL_TRISTATE)
		else $error("tri-state select still drives");
	header_a: assert property ( // RULE7
		(s_r.st == srm_pkg::ST_HDR && byte_done && !spi_cs_n) |=>
		 s_r.addr == $past(byte_in[5:0]) && s_r.rnw == $past(byte_in[7]))
		else $error("header fields misdecoded");
	strobe_pulse_a: assert property ( // RULE2
		strobe_valid |=> !strobe_valid)
		else $error("strobe longer than one cycle");

	cov_burst_write: cover property (
		s_r.burst && !s_r.rnw && byte_done ##[1:300] byte_done);
	cov_status_read: cover property (
		s_r.rnw && s_r.burst && s_r.addr == srm_pkg::MAIN_ST_ADDR && fall);
	cov_strobe: cover property (strobe_valid);
	cov_aux_driven: cover property ($rose(aux_pin_oe));

endmodule : srm_regmap

// ===== tb/srm_host.sv
// host side serial master model driving the register map
`timescale 1ns/1ns
module srm_host (
	input  wire logic mclk,     // system clock
	output logic      spi_sclk, // serial clock, idle low
	output logic      spi_cs_n, // chip select, active low
	output logic      spi_mosi, // data to the device
	input  wire logic spi_miso  // data from the device
);
	// ------------------------------------------------------------
	// idle levels
	// ------------------------------------------------------------
	initial
	begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// ------------------------------------------------------------
	// one byte, msb first, mode 0
	// ------------------------------------------------------------
	// lag stretches the low phase to act as a slow host
	task automatic shift(input logic [7:0] tx, input int lag,
		output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			@(posedge mclk);
			#1 spi_mosi = tx[i];
			repeat (3 + lag) @(posedge mclk);
			#1 spi_sclk = 1'b1;
			rx[i] = spi_miso;
			repeat (4) @(posedge mclk);
			#1 spi_sclk = 1'b0;
		end
	endtask : shift

	// ------------------------------------------------------------
	// whole frame: header then n data bytes
	// ------------------------------------------------------------
	task automatic access(input logic [7:0] hdr, input int n,
		input int lag, input logic [7:0] wd [8],
		output logic [7:0] st, output logic [7:0] rd [8]);
		@(posedge mclk);
		#1 spi_cs_n = 1'b0;
		shift(hdr, lag, st);
		for (int k = 0; k < n; k++)
			shift(wd[k], lag, rd[k]);
		repeat (4) @(posedge mclk);
		#1 spi_cs_n = 1'b1;
		// mosi is meaningless now, so do not leave the last bit
		spi_mosi = ~spi_mosi;
		// gap between frames is longer than two cycles
		repeat (3) @(posedge mclk);
	endtask : access
endmodule : srm_host

// ===== tb/srm_regmap_bench.sv
// self-checking bench of the serial register map
`timescale 1ns/1ns
`define CHK(got, exp) \
	begin \
		checked++; \
		if ((got) !== (exp)) \
		begin \
			errors++; \
			$display("ERROR %0t got %h exp %h", $time, got, exp); \
		end \
	end
module srm_regmap_bench;
	logic       mclk, rst_n, sclk, cs_n, mosi, miso, miso_oe;
	logic [7:0] chip_status, main_st, pkt_st, tx_cnt; // status inputs
	logic       aux_signal;       // signal routed to the pin
	logic       strobe_valid, tx_wr_valid, drive, pin_o, pin_oe;
	logic [5:0] strobe_code, sel; // strobe address, select field
	logic [7:0] tx_wr_data;       // buffer byte
	logic [7:0] wbuf [8];         // bytes sent after the header
	logic [7:0] rbuf [8];         // bytes returned
	logic [7:0] st;               // byte returned under the header
	logic [7:0] sh [4] = '{8'hF5, 8'hF8, 8'hFA, 8'hFB}; // status reads
	logic [7:0] sx [4] = '{8'h1D, 8'hA4, 8'h27, 8'h00}; // their values
	int         errors, checked, stb_n, tx_n, oe_n, n0;

	srm_regmap srm_regmap_inst (
		.mclk(mclk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
		.spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
		.chip_status(chip_status), .main_state_status(main_st),
		.packet_status(pkt_st), .tx_byte_count(tx_cnt),
		.aux_signal(aux_signal), .strobe_valid(strobe_valid),
		.strobe_code(strobe_code), .tx_wr_valid(tx_wr_valid),
		.tx_wr_data(tx_wr_data), .aux_pin_signal_select(sel),
		.output_drive_strength(drive), .aux_pin_o(pin_o),
		.aux_pin_oe(pin_oe));

	srm_host srm_host_inst (
		.mclk(mclk), .spi_sclk(sclk), .spi_cs_n(cs_n),
		.spi_mosi(mosi), .spi_miso(miso));

	// ------------------------------------------------------------
	// clock, pulse counters, watchdog
	// ------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// pulses last one cycle, so count them at every edge
	always @(posedge mclk)
	begin
		if (strobe_valid === 1'b1)
			stb_n++;
		if (tx_wr_valid === 1'b1)
			tx_n++;
		// cycles with miso driven, one frame is counted exactly
		if (miso_oe === 1'b1)
			oe_n++;
	end

	// a hang counts as a mismatch and closes the run
	initial
	begin
		repeat (40000) @(posedge mclk);
		errors++;
		$display("ERROR %0t run did not finish", $time);
		close_out();
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// one frame, then let the closing edge's updates land
	task automatic xf(input logic [7:0] hdr, input int n, input int lag);
		srm_host_inst.access(hdr, n, lag, wbuf, st, rbuf);
		#1;
	endtask : xf

	task automatic test_end(input string name);
		$display("test done: %s", name);
	endtask : test_end

	task close_out;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		errors = 0;
		checked = 0;
		stb_n = 0;
		tx_n = 0;
		oe_n = 0;
		// no unknown bits on mosi during read frames
		wbuf = '{default: 8'h00};
		rst_n = 1'b0;
		chip_status = 8'h96;
		main_st = 8'h1D;
		pkt_st = 8'hA4;
		tx_cnt = 8'h27;
		aux_signal = 1'b0;
		repeat (8) @(posedge mclk);
		#1 rst_n = 1'b1;
		`CHK(sel, srm_pkg::SEL_TRISTATE)
		`CHK(pin_oe, 1'b0)
		`CHK(drive, 1'b0)
		`CHK(miso_oe, 1'b0)
		n0 = oe_n;
		xf(8'h81, 1, 0);
		`CHK(rbuf[0], srm_pkg::AUX_CFG_RESET)
		`CHK(st, 8'h96)
		// two bytes of 64 cycles, four tail cycles
		`CHK(oe_n - n0, 132)
		`CHK(miso_oe, 1'b0)
		test_end("reset values");

		wbuf[0] = 8'hC5;
		xf(8'h01, 1, 0);
		`CHK(sel, 6'h05)
		`CHK(drive, 1'b1)
		`CHK(pin_oe, 1'b1)
		repeat (2) @(posedge mclk);
		`CHK(pin_o, 1'b1)
		#1 aux_signal = 1'b1;
		repeat (2) @(posedge mclk);
		`CHK(pin_o, 1'b0)
		xf(8'h81, 1, 0);
		`CHK(rbuf[0], 8'hC5)
		test_end("single write");

		// burst from 0x00 with a slow host
		wbuf = '{8'h11, 8'h4A, 8'h33, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
		xf(8'h40, 3, 5);
		`CHK(sel, 6'h0A)
		`CHK(drive, 1'b0)
		repeat (2) @(posedge mclk);
		`CHK(pin_o, 1'b0)
		xf(8'hC0, 3, 0);
		for (int k = 0; k < 3; k++)
			`CHK(rbuf[k], wbuf[k])
		test_end("burst access");

		n0 = stb_n;
		for (int k = 0; k < 4; k++)
		begin
			xf(sh[k], 1, 0);
			`CHK(rbuf[0], sx[k])
		end
		`CHK(stb_n, n0)
		test_end("status reads");

		for (logic [5:0] a = 6'h31; a <= 6'h3D; a++)
		begin
			n0 = stb_n;
			xf({a[0], 1'b0, a}, 0, 0);
			`CHK(stb_n, n0 + 1)
			`CHK(strobe_code, a)
		end
		`CHK(sel, 6'h0A)
		test_end("strobes");

		// buffer and table are not plain storage
		n0 = tx_n;
		wbuf[0] = 8'hA1;
		wbuf[1] = 8'hB2;
		wbuf[2] = 8'h5C;
		xf(8'h7F, 3, 0);
		`CHK(tx_n, n0 + 3)
		`CHK(tx_wr_data, 8'h5C)
		xf(8'h7E, 2, 0);
		xf(8'hFE, 2, 0);
		`CHK(rbuf[0], 8'hA1)
		`CHK(rbuf[1], 8'hB2)
		test_end("buffer and table");

		xf(8'h30, 0, 0);
		`CHK(strobe_code, srm_pkg::RESET_STB_ADDR)
		`CHK(sel, srm_pkg::SEL_TRISTATE)
		`CHK(pin_oe, 1'b0)
		xf(8'hC0, 2, 0);
		`CHK(rbuf[0], 8'h00)
		`CHK(rbuf[1], srm_pkg::AUX_CFG_RESET)
		test_end("soft reset");
		close_out();
	end
endmodule : srm_regmap_bench
